//--- src/rtw_slave_port.sv
`timescale 1ns/1ps
module rtw_slave_port (
    input wire logic I_MCLK,                 // System clock 100 MHz
    input wire logic I_RST_N,                // Asynchronous reset, active low
    input wire logic I_CE,                   // Clock enable, freezes state when low
    input wire rtw_pkg::rtw_bus_t I_BUS,     // SCL and SDA pin levels
    output logic O_SDA_O,                    // SDA output level, always low
    output logic O_SDA_OE,                   // SDA pulled low while high
    output logic O_BUSY                      // Transfer in progress
);
    import rtw_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_WRX  = 5'b00100,
        ST_RTX  = 5'b01000,
        ST_SKIP = 5'b10000
    } rtw_state_t;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] scl_sy;
    logic [SYNC_STAGES-1:0] sda_sy;
    logic scl;
    logic sda;
    logic scl_q;
    logic sda_q;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            scl_sy <= '1;
            sda_sy <= '1;
        end else if (I_CE) begin
            scl_sy <= {scl_sy[SYNC_STAGES-2:0], I_BUS.scl};
            sda_sy <= {sda_sy[SYNC_STAGES-2:0], I_BUS.sda};
        end
    end

    // Filtered levels, held while the last two stages disagree
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            scl <= 1'b1;
            sda <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (I_CE) begin
            if (scl_sy[1] == scl_sy[2]) begin
                scl <= scl_sy[2];
            end
            if (sda_sy[1] == sda_sy[2]) begin
                sda <= sda_sy[2];
            end
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // ------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------
    logic start_c;
    logic stop_c;
    logic scl_rise;
    logic scl_fall;
    assign start_c = scl && scl_q && sda_q && !sda;
    assign stop_c = scl && scl_q && !sda_q && sda;
    assign scl_rise = scl && !scl_q;
    assign scl_fall = !scl && scl_q;

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    rtw_state_t state;
    logic [BIT_W-1:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx_byte;
    logic first_wr;
    logic in_ack;
    logic ack_fail;
    logic [PTR_W-1:0] ptr;
    logic [7:0] regs [REG_COUNT];
    logic [7:0] next_shreg;
    logic bit_live;

    assign in_ack = (bit_cnt == ACK_SLOT);
    assign next_shreg = {shreg[6:0], sda};          // MSB first

    // Bit counter, sampling on SCL rise and stepping on SCL fall
    // The SCL fall that closes a START is no bit boundary, so wait for a rise
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bit_cnt <= '0;
            shreg <= 8'h00;
            bit_live <= 1'b0;
        end else if (I_CE) begin
            if (start_c) begin
                bit_cnt <= '0;
                bit_live <= 1'b0;
            end else if (scl_rise) begin
                bit_live <= 1'b1;
                if (!in_ack) begin
                    shreg <= next_shreg;
                end
            end else if (scl_fall && bit_live && state != ST_IDLE && state != ST_SKIP) begin
                bit_cnt <= in_ack ? '0 : bit_cnt + 1'b1;
            end
        end
    end

    // State sequencing and pointer handling
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state <= ST_IDLE;
            ptr <= '0;
            first_wr <= 1'b0;
            ack_fail <= 1'b0;
        end else if (I_CE) begin
            if (start_c) begin
                state <= ST_ADDR;
                ack_fail <= 1'b0;
            end else if (stop_c) begin
                state <= ST_IDLE;
            end else if (scl_rise && in_ack && state == ST_RTX) begin
                ack_fail <= sda;
                if (!sda) begin
                    ptr <= ptr + 1'b1;
                end
            end else if (scl_fall && in_ack) begin
                case (state)
                    ST_ADDR: begin
                        if (shreg[7:1] != SLAVE_ADDR) begin
                            state <= ST_SKIP;
                        end else if (shreg[0]) begin
                            state <= ST_RTX;
                        end else begin
                            state <= ST_WRX;
                            first_wr <= 1'b1;
                        end
                    end
                    ST_WRX: begin
                        if (first_wr) begin
                            ptr <= shreg[PTR_W-1:0];
                            first_wr <= 1'b0;
                        end else begin
                            ptr <= ptr + 1'b1;
                        end
                    end
                    ST_RTX: begin
                        if (ack_fail) begin
                            state <= ST_SKIP;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // Register bytes; wrap of the pointer covers all eight
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RESET;
            end
        end else if (I_CE) begin
            if (scl_fall && in_ack && state == ST_WRX && !first_wr) begin
                regs[ptr] <= shreg;
            end
        end
    end

    // Load the outgoing byte when a read byte begins
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_byte <= 8'hff;
        end else if (I_CE) begin
            if (state == ST_RTX && bit_cnt == '0 && !scl) begin
                tx_byte <= regs[ptr];
            end
        end
    end

    // SDA drive, changed while SCL is low to avoid false conditions, and released at once on START or STOP
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SDA_OE <= 1'b0;
        end else if (I_CE) begin
            if (start_c || stop_c) begin
                O_SDA_OE <= 1'b0;
            end else if (!scl) begin
                if (in_ack) begin
                    O_SDA_OE <= (state == ST_WRX) ||
                        (state == ST_ADDR && shreg[7:1] == SLAVE_ADDR);
                end else if (state == ST_RTX && !ack_fail) begin
                    O_SDA_OE <= !tx_byte[3'(7 - bit_cnt[2:0])];
                end else begin
                    O_SDA_OE <= 1'b0;
                end
            end
        end
    end

    // Constant low drive level and busy flag
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SDA_O <= 1'b0;
            O_BUSY <= 1'b0;
        end else if (I_CE) begin
            O_SDA_O <= 1'b0;
            O_BUSY <= (state != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_drive_scl_low: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_CE && scl && scl_q && $changed(O_SDA_OE)) |-> $past(start_c || stop_c))
        else $error("SDA drive changed while SCL high");
    a_stop_idle: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_CE && stop_c && !start_c) |=> state == ST_IDLE)
        else $error("STOP did not return to idle");
    a_start_addr: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_CE && start_c) |=> (state == ST_ADDR && bit_cnt == '0))
        else $error("START did not restart address");
    a_skip_quiet: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (state == ST_SKIP && $past(state) == ST_SKIP) |-> !O_SDA_OE)
        else $error("Drive while not addressed");
    a_wr_ack: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_CE && state == ST_WRX && in_ack && !scl && !start_c && !stop_c) |=> O_SDA_OE)
        else $error("Write byte not acknowledged");
    a_nack_release: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (ack_fail && (state == ST_RTX || state == ST_SKIP)) |-> !O_SDA_OE)
        else $error("SDA held after missing acknowledge");
    a_rd_ptr_step: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_CE && scl_rise && in_ack && state == ST_RTX && !start_c && !stop_c)
        |=> ptr == $past(ptr) + ($past(sda) ? 3'd0 : 3'd1))
        else $error("Read pointer step wrong");
    a_wr_ptr_load: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_CE && scl_fall && in_ack && state == ST_WRX && first_wr && !start_c && !stop_c)
        |=> ptr == $past(shreg[2:0]))
        else $error("Word address not loaded");
    a_busy_flag: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        (I_CE && state == ST_IDLE) |=> !O_BUSY)
        else $error("Busy while idle");
endmodule

//--- src/rtw_pkg.sv
package rtw_pkg;
    // ------------------------------------------------------------
    // Bus protocol constants
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h68;   // Upper seven bits of address byte 0xd0
    localparam int REG_COUNT = 8;                // Calendar and control bytes
    localparam int PTR_W = 3;
    localparam int BIT_W = 4;
    localparam logic [3:0] ACK_SLOT = 4'h8;      // Ninth bit time of each byte
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int SYNC_STAGES = 3;

    // Bus line carrier
    typedef struct packed {
        logic scl;
        logic sda;
    } rtw_bus_t;
endpackage

//--- sim/rtw_master_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus master model, 160 ns bit time, lines released high
// ------------------------------------------------------------
module rtw_master_model (
    input wire logic i_sda,   // Resolved data line
    output logic o_scl,       // Serial clock, idle high
    output logic o_sda        // Data drive, high = released
);
    // Clock stands high between frames, so the bus starts idle
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Data is raised while the clock is low, then falls under a high clock
    task automatic start();
        #40 o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b0;
        #80 o_scl = 1'b0;
    endtask
    // Data rises under a high clock and the bus is left idle
    task automatic stop();
        #50 o_sda = 1'b0;
        #30 o_scl = 1'b1;
        #80 o_sda = 1'b1;
        #80;
    endtask
    // Data set only in the low phase; waits past the ack release
    task automatic bit_x(input logic b, output logic s);
        #50 o_sda = b;
        #30 o_scl = 1'b1;
        #40 s = i_sda;
        #40 o_scl = 1'b0;
    endtask
    // One byte MSB first, then the ninth acknowledge pulse
    task automatic xfer(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(m_ack, a);
    endtask
endmodule

//--- sim/rtw_testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Slave port bench: write/read-back rows, then edge cases
// ------------------------------------------------------------
module testbench;
    import rtw_pkg::*;
    typedef struct packed {
        logic [2:0] ptr;
        logic [7:0] data;
    } rtw_row_t;
    logic mclk, rst_n, scl, sda_m, sda_o, sda_oe, busy, ak;
    logic [7:0] rd;
    logic [7:0] mem [8];
    int n_errors, n_checks;
    int cycles = 0;
    rtw_bus_t bus;
    rtw_row_t rows [8];
    // Pull-up wins unless the master or the device pulls the line low
    wire sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
    assign bus = {scl, sda_w};

    rtw_slave_port dut (.I_MCLK(mclk), .I_RST_N(rst_n), .I_CE(1'b1), .I_BUS(bus),
                        .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .O_BUSY(busy));
    rtw_master_model m (.i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));

    // 100 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Cycle ceiling, about twice the expected run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // START plus slave address; ack level expected from the device
    task automatic addr(input logic [7:0] a, input logic exp_ack);
        m.start();
        m.xfer(a, 1'b1, rd, ak);
        check("addr ack", {7'h0, ak}, {7'h0, exp_ack});
        if (!exp_ack) begin
            check("busy", {7'h0, busy}, 8'h01);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        m.xfer(d, 1'b1, rd, ak);
        check("data ack", {7'h0, ak}, 8'h00);
    endtask
    task automatic rdb(input logic m_ack, input logic [7:0] exp);
        m.xfer(8'hff, m_ack, rd, ak);
        check("read data", rd, exp);
    endtask
    task automatic fin();
        m.stop();
        check("busy after stop", {7'h0, busy}, 8'h00);
    endtask

    // Main sequence
    initial begin
        n_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        rows = '{'{3'h7, 8'h80}, '{3'h0, 8'h59}, '{3'h1, 8'h47}, '{3'h2, 8'h23},
                 '{3'h3, 8'h07}, '{3'h4, 8'h31}, '{3'h5, 8'h12}, '{3'h6, 8'h99}};
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        repeat (12) @(negedge mclk);
        check("outputs in reset", {5'h0, sda_o, sda_oe, busy}, 8'h00);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        addr(8'hd1, 1'b0);
        rdb(1'b1, 8'h00);
        fin();
        // Rows: load pointer, write, repeated START, read back
        foreach (rows[i]) begin
            addr(8'hd0, 1'b0);
            wr({5'h0, rows[i].ptr});
            wr(rows[i].data);
            mem[rows[i].ptr] = rows[i].data;
            addr(8'hd0, 1'b0);
            wr({5'h0, rows[i].ptr});
            addr(8'hd1, 1'b0);
            rdb(1'b1, rows[i].data);
            fin();
        end
        // Burst over all locations and wrap; nack on the last
        addr(8'hd0, 1'b0);
        wr(8'h00);
        addr(8'hd1, 1'b0);
        for (int i = 0; i < 9; i++) begin
            rdb(i == 8, mem[i % 8]);
        end
        #100 check("oe after nack", {7'h0, sda_oe}, 8'h00);
        fin();
        // Write past the top, then bare reads from the held pointer
        addr(8'hd0, 1'b0);
        wr(8'h06);
        for (int i = 0; i < 3; i++) begin
            wr(8'h21 + i[7:0]);
            mem[(6 + i) % 8] = 8'h21 + i[7:0];
        end
        fin();
        addr(8'hd1, 1'b0);
        rdb(1'b0, mem[1]);
        rdb(1'b1, mem[2]);
        fin();
        addr(8'hd1, 1'b0);
        rdb(1'b1, mem[2]);
        fin();
        // Foreign address must be ignored, bytes included
        addr(8'ha0, 1'b1);
        m.xfer(8'h03, 1'b1, rd, ak);
        m.xfer(8'h77, 1'b1, rd, ak);
        check("ignored ack", {7'h0, ak}, 8'h01);
        // START after half a byte restarts address reception
        m.start();
        repeat (4) m.bit_x(1'b1, ak);
        addr(8'hd0, 1'b0);
        wr(8'h03);
        addr(8'hd1, 1'b0);
        rdb(1'b1, mem[3]);
        fin();
        // Reset in mid-transfer clears pointer and register bytes
        addr(8'hd0, 1'b0);
        wr(8'h05);
        repeat (2) @(negedge mclk);
        rst_n = 1'b0;
        repeat (12) @(negedge mclk);
        check("outputs in mid reset", {5'h0, sda_o, sda_oe, busy}, 8'h00);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        addr(8'hd1, 1'b0);
        rdb(1'b1, 8'h00);
        fin();
        end_sim();
    end
endmodule
